// ===== hdl/vdc_control_port.sv
`timescale 1ns/1ps
`default_nettype none
module vdc_control_port (
  // System clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Serial control bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_select_pin_i,
  // Video side, on the pixel clock.
  input wire logic pixel_clock_i,
  input wire logic fast_float_n_i,
  input wire logic killer_detect_i,
  input wire logic line_lock_flag_i,
  input wire logic line_count_ident_i,
  input wire logic [3:0] chroma_bus_in_i,
  input wire logic [6:0] luma_in_i,
  input wire logic [6:0] luma_limited_i,
  input wire logic [3:0] chroma_in_i,
  input wire logic sync_line_i,
  input wire logic sync_field_i,
  input wire logic video_gate_i,
  // Video outputs with enables.
  output logic [6:0] luma_bus_o,
  output logic luma_bus_oe_o,
  output logic [3:0] chroma_bus_o,
  output logic chroma_bus_oe_o,
  output logic line_sync_out_o,
  output logic field_sync_out_o,
  output logic video_gate_out_o,
  output logic sync_gate_oe_o,
  // Timing settings toward the line logic.
  output logic [8:0] increment_delay_o,
  output logic line_loop_open_o,
  output logic [7:0] line_sync_pulse_start_o,
  output logic [7:0] line_sync_pulse_stop_o,
  output logic [7:0] clamp_pulse_start_o,
  output logic [7:0] clamp_pulse_stop_o,
  output logic [7:0] line_sync_out_start_o,
  output logic [7:0] luma_peaking_o,
  output logic [7:0] hue_phase_o,
  output logic [7:0] standard_control_o,
  output logic [7:0] input_delay_control_o,
  output logic [6:0] secam_chroma_delay_bits_o
);

  // Register file, system domain.
  logic [7:0] regs [0:11];
  logic [7:0] subaddr;
  vdc_pkg::vdc_state_t state;
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic is_read;
  logic have_sub;
  logic ack_drive;
  logic reset_seen_flag;
  logic [7:0] status_snap;

  // Three-stage samplers; a level counts once stages two and three agree.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      scl_s <= 3'b111;
      sda_s <= 3'b111;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      if (scl_s[2] == scl_s[1]) scl_q <= scl_s[2];
      if (sda_s[2] == sda_s[1]) sda_q <= sda_s[2];
    end
  end

  // Filtered bus events.
  wire scl_now = (scl_s[2] == scl_s[1]) ? scl_s[2] : scl_q;
  wire sda_now = (sda_s[2] == sda_s[1]) ? sda_s[2] : sda_q;
  wire scl_rise = scl_now & ~scl_q;
  wire scl_fall = ~scl_now & scl_q;
  wire start_cond = scl_q & scl_now & sda_q & ~sda_now;
  wire stop_cond = scl_q & scl_now & ~sda_q & sda_now;
  wire [6:0] my_addr = addr_select_pin_i ? vdc_pkg::SLAVE_ADDR_HIGH : vdc_pkg::SLAVE_ADDR_LOW;
  wire addr_match = (shreg[7:1] == my_addr);
  wire sub_acked = (subaddr <= vdc_pkg::SUB_LAST_ACKED);
  wire byte_done = scl_rise & (bit_cnt == 4'd7);
  wire [7:0] byte_in = {shreg[6:0], sda_now};

  // Next subaddress with wrap from the top of the decoded window.
  function automatic logic [7:0] next_sub(input logic [7:0] s);
    next_sub = (s == vdc_pkg::SUB_WRAP) ? 8'h00 : s + 8'h01;
  endfunction

  // Status byte, driven once the flags have been brought into this domain below.
  wire [7:0] status_byte;

  // Bus engine: address, subaddress and data bytes, with acknowledge slots.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= vdc_pkg::VDC_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      is_read <= 1'b0;
      have_sub <= 1'b0;
      ack_drive <= 1'b0;
      subaddr <= 8'h00;
      status_snap <= 8'h00;
    end else if (start_cond) begin
      state <= vdc_pkg::VDC_ADDR;
      bit_cnt <= 4'h0;
      have_sub <= 1'b0;
      ack_drive <= 1'b0;
    end else if (stop_cond) begin
      state <= vdc_pkg::VDC_IDLE;
      ack_drive <= 1'b0;
    end else begin
      case (state)
        vdc_pkg::VDC_IDLE: begin
          ack_drive <= 1'b0;
        end
        vdc_pkg::VDC_ADDR, vdc_pkg::VDC_WDATA: begin
          if (scl_rise) begin
            shreg <= byte_in;
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done) begin
            state <= (state == vdc_pkg::VDC_ADDR) ? vdc_pkg::VDC_ADDR_ACK : vdc_pkg::VDC_WACK;
          end
        end
        vdc_pkg::VDC_ADDR_ACK: begin
          if (scl_fall && !ack_drive) begin
            if (addr_match) begin
              ack_drive <= 1'b1;
              is_read <= shreg[0];
              status_snap <= status_byte;
            end else begin
              state <= vdc_pkg::VDC_SKIP;
            end
          end else if (scl_fall && ack_drive) begin
            ack_drive <= 1'b0;
            bit_cnt <= 4'h0;
            shreg <= status_snap;
            state <= is_read ? vdc_pkg::VDC_RDATA : vdc_pkg::VDC_WDATA;
          end
        end
        vdc_pkg::VDC_WACK: begin
          if (scl_fall && !ack_drive) begin
            if (!have_sub) begin
              subaddr <= shreg;
              have_sub <= 1'b1;
              ack_drive <= (shreg <= vdc_pkg::SUB_LAST_ACKED);
              if (shreg > vdc_pkg::SUB_LAST_ACKED) state <= vdc_pkg::VDC_SKIP;
            end else begin
              ack_drive <= sub_acked;
              subaddr <= next_sub(subaddr);
              if (!sub_acked) state <= vdc_pkg::VDC_SKIP;
            end
          end else if (scl_fall && ack_drive) begin
            ack_drive <= 1'b0;
            bit_cnt <= 4'h0;
            state <= vdc_pkg::VDC_WDATA;
          end
        end
        vdc_pkg::VDC_RDATA: begin
          if (scl_fall) begin
            shreg <= {shreg[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'd7) state <= vdc_pkg::VDC_RACK;
          end
        end
        vdc_pkg::VDC_RACK: begin
          // The next byte starts only after the clock falls, so the line never moves while it is high.
          if (scl_rise && sda_now) begin
            state <= vdc_pkg::VDC_SKIP;
          end else if (scl_fall) begin
            state <= vdc_pkg::VDC_RDATA;
            shreg <= status_byte;
            bit_cnt <= 4'h0;
          end
        end
        vdc_pkg::VDC_SKIP: begin
          ack_drive <= 1'b0;
        end
        default: begin
          state <= vdc_pkg::VDC_IDLE;
        end
      endcase
    end
  end

  // Register write happens as the data byte completes inside an acked window.
  wire wr_strobe = byte_done & (state == vdc_pkg::VDC_WDATA) & have_sub & sub_acked;
  wire [3:0] wr_index = subaddr[3:0];

  // Control registers 1 to 3 are cleared except the luma delay bits; the rest stay undefined.
  // All writes sit in this one process so that each register has a single driver.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      regs[8] <= vdc_pkg::STANDARD_CONTROL_RST;
      regs[9] <= vdc_pkg::OUTPUT_CONTROL_RST;
      regs[10][7:3] <= vdc_pkg::INPUT_DELAY_UPPER_RST;
    end else if (wr_strobe && wr_index < vdc_pkg::NUM_REGS) begin
      regs[wr_index] <= byte_in;
    end
  end

  // Power-on flag stays set until the first status read has completed.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      reset_seen_flag <= 1'b1;
    end else if (state == vdc_pkg::VDC_RACK && scl_rise) begin
      reset_seen_flag <= 1'b0;
    end
  end

  // Open-drain data line: low for acknowledge or a zero read bit.
  assign sda_oe_o = ack_drive | (state == vdc_pkg::VDC_RDATA && !shreg[7]);
  assign sda_o = 1'b0;

  // Timing words handed out as stored, increment delay with a fixed 1 on bit 8; lower codes mean later edges.
  assign increment_delay_o = {1'b1, regs[0]};
  assign line_sync_pulse_start_o = regs[1];
  assign line_sync_pulse_stop_o = regs[2];
  assign clamp_pulse_start_o = regs[3];
  assign clamp_pulse_stop_o = regs[4];
  assign line_sync_out_start_o = regs[5];
  assign luma_peaking_o = regs[6];
  assign hue_phase_o = regs[7];
  assign standard_control_o = regs[8];
  assign input_delay_control_o = regs[10];
  assign secam_chroma_delay_bits_o = regs[11][6:0];

  // Codes past the central counter range force the line loop open.
  wire field_rate = regs[8][vdc_pkg::STD_FIELD_RATE];
  wire [7:0] increment_delay_limit = field_rate ? vdc_pkg::INCREMENT_DELAY_LIMIT_525 : vdc_pkg::INCREMENT_DELAY_LIMIT_625;
  assign line_loop_open_o = regs[8][vdc_pkg::STD_LINE_LOOP_OPEN] | (regs[0] < increment_delay_limit);

  // Pixel domain: crossing of control levels, three stages, second and third agree.
  logic [2:0] ctl_s [0:5];
  logic [5:0] ctl_p;
  wire [5:0] ctl_sys = {regs[9][vdc_pkg::OUT_VNL], regs[9][vdc_pkg::OUT_LUMA_OE],
    regs[9][vdc_pkg::OUT_CHROMA_OE], regs[9][vdc_pkg::OUT_CHROMA_FORCED],
    regs[8][vdc_pkg::STD_CHROMA_ON], field_rate};
  logic [2:0] foe_s;
  logic foe_n_p;
  always_ff @(posedge pixel_clock_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 6; i++) ctl_s[i] <= 3'b000;
      ctl_p <= 6'h00;
      foe_s <= 3'b111;
      foe_n_p <= 1'b1;
    end else begin
      for (int i = 0; i < 6; i++) begin
        ctl_s[i] <= {ctl_s[i][1:0], ctl_sys[i]};
        if (ctl_s[i][2] == ctl_s[i][1]) ctl_p[i] <= ctl_s[i][2];
      end
      foe_s <= {foe_s[1:0], fast_float_n_i};
      if (foe_s[2] == foe_s[1]) foe_n_p <= foe_s[2];
    end
  end

  // Line counter and SECAM ident sample at the fixed cycle of each line.
  logic [10:0] line_cnt;
  logic secam_ident_bit;
  wire [10:0] line_len = ctl_p[0] ? vdc_pkg::LINE_LENGTH_525 : vdc_pkg::LINE_LENGTH_625;
  always_ff @(posedge pixel_clock_i or posedge reset_i) begin
    if (reset_i) begin
      line_cnt <= 11'd0;
      secam_ident_bit <= 1'b0;
    end else begin
      line_cnt <= (line_cnt >= line_len - 11'd1) ? 11'd0 : line_cnt + 11'd1; // Mode change past the end.
      if (line_cnt == vdc_pkg::SECAM_SAMPLE_CYCLE) secam_ident_bit <= chroma_bus_in_i[vdc_pkg::STATUS_CHROMA_IDENT];
    end
  end

  // Video outputs: luma through limiter choice, chroma gated by colour logic.
  wire colour_on = ctl_p[1] & (ctl_p[2] | killer_detect_i);
  wire data_float = ~foe_n_p;
  always_ff @(posedge pixel_clock_i or posedge reset_i) begin
    if (reset_i) begin
      luma_bus_o <= 7'h00;
      chroma_bus_o <= 4'h0;
      luma_bus_oe_o <= 1'b0;
      chroma_bus_oe_o <= 1'b0;
      sync_gate_oe_o <= 1'b0;
      line_sync_out_o <= 1'b0;
      field_sync_out_o <= 1'b0;
      video_gate_out_o <= 1'b0;
    end else begin
      luma_bus_o <= ctl_p[5] ? luma_limited_i : luma_in_i;
      chroma_bus_o <= colour_on ? chroma_in_i : 4'h0;
      luma_bus_oe_o <= ctl_p[4] & ~data_float;
      chroma_bus_oe_o <= ctl_p[3] & ~data_float;
      sync_gate_oe_o <= ctl_p[4];
      line_sync_out_o <= sync_line_i;
      field_sync_out_o <= sync_field_i;
      video_gate_out_o <= video_gate_i;
    end
  end

  // Status flags into the system domain.
  logic [2:0] st_s [0:3];
  logic [3:0] st_q;
  wire [3:0] st_in = {line_lock_flag_i, line_count_ident_i, killer_detect_i, secam_ident_bit};
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 4; i++) st_s[i] <= 3'b000;
      st_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        st_s[i] <= {st_s[i][1:0], st_in[i]};
        if (st_s[i][2] == st_s[i][1]) st_q[i] <= st_s[i][2];
      end
    end
  end
  wire line_lock_sys = st_q[3];
  wire line_count_sys = st_q[2];
  wire killer_sys = st_q[1];
  wire secam_ident_sys = st_q[0];
  assign status_byte = vdc_pkg::STATUS_FIXED | {reset_seen_flag, line_lock_sys, 1'b0,
    line_count_sys, 1'b0, killer_sys, secam_ident_sys, 1'b0};

endmodule
`default_nettype wire

// ===== hdl/vdc_pkg.sv
package vdc_pkg;
  // Subaddress map of the control port.
  localparam logic [7:0] SUB_INCREMENT_DELAY = 8'h00;
  localparam logic [7:0] SUB_LINE_SYNC_PULSE_START = 8'h01;
  localparam logic [7:0] SUB_LINE_SYNC_PULSE_STOP = 8'h02;
  localparam logic [7:0] SUB_CLAMP_PULSE_START = 8'h03;
  localparam logic [7:0] SUB_CLAMP_PULSE_STOP = 8'h04;
  localparam logic [7:0] SUB_LINE_SYNC_OUT_START = 8'h05;
  localparam logic [7:0] SUB_LUMA_PEAKING = 8'h06;
  localparam logic [7:0] SUB_HUE_PHASE = 8'h07;
  localparam logic [7:0] SUB_STANDARD_CONTROL = 8'h08;
  localparam logic [7:0] SUB_OUTPUT_CONTROL = 8'h09;
  localparam logic [7:0] SUB_INPUT_DELAY_CONTROL = 8'h0A;
  localparam logic [7:0] SUB_SECAM_CHROMA_DELAY = 8'h0B;
  localparam logic [7:0] SUB_LAST_ACKED = 8'h0F;
  localparam logic [7:0] SUB_WRAP = 8'h1F;
  localparam logic [3:0] NUM_REGS = 4'hC;
  // Slave addresses (upper seven bits) selected by the strap.
  localparam logic [6:0] SLAVE_ADDR_LOW = 7'h45;
  localparam logic [6:0] SLAVE_ADDR_HIGH = 7'h47;
  // Reset values of control registers 1 to 3.
  localparam logic [7:0] STANDARD_CONTROL_RST = 8'h00;
  localparam logic [7:0] OUTPUT_CONTROL_RST = 8'h00;
  localparam logic [4:0] INPUT_DELAY_UPPER_RST = 5'h00;
  // Field positions.
  localparam int STD_LINE_LOOP_OPEN = 7;
  localparam int STD_FIELD_RATE = 6;
  localparam int STD_CHROMA_ON = 4;
  localparam int OUT_VNL = 7;
  localparam int OUT_LUMA_OE = 6;
  localparam int OUT_CHROMA_OE = 5;
  localparam int OUT_CHROMA_FORCED = 3;
  localparam int STATUS_CHROMA_IDENT = 2;
  // Line timing in pixel clock cycles.
  localparam logic [10:0] SECAM_SAMPLE_CYCLE = 11'd748;
  localparam logic [10:0] LINE_LENGTH_625 = 11'd864;
  localparam logic [10:0] LINE_LENGTH_525 = 11'd858;
  // Increment delay codes below these leave the central counter range.
  localparam logic [7:0] INCREMENT_DELAY_LIMIT_625 = 8'h28;
  localparam logic [7:0] INCREMENT_DELAY_LIMIT_525 = 8'h2A;
  // Fixed status bits.
  localparam logic [7:0] STATUS_FIXED = 8'h20;
  // Bus engine states.
  typedef enum logic [2:0] {
    VDC_IDLE = 3'b000,
    VDC_ADDR = 3'b001,
    VDC_ADDR_ACK = 3'b010,
    VDC_WDATA = 3'b011,
    VDC_WACK = 3'b100,
    VDC_RDATA = 3'b101,
    VDC_RACK = 3'b110,
    VDC_SKIP = 3'b111
  } vdc_state_t;
endpackage

// ===== testbench/vdc_pip_model.sv
`timescale 1ns/1ps
`default_nettype none
module vdc_pip_model (
  // Pixel clock and request from the bench.
  input wire logic pixel_clock_i,
  input wire logic float_req_i,
  // Shared video bus controls.
  output logic fast_float_n_o,
  output logic [3:0] chroma_bus_in_o
);
  logic [3:0] pat = 4'h0;
  initial fast_float_n_o = 1'b1;
  // The float request is retimed to the pixel grid, as a real overlay controller would.
  always @(posedge pixel_clock_i) begin
    pat <= pat + 4'h1;
    fast_float_n_o <= !float_req_i;
  end
  // The ident bit sits on bit 2; the other bits keep moving so stale values never look valid.
  assign chroma_bus_in_o = {pat[3], 1'b1, pat[1:0]};
endmodule
`default_nettype wire

// ===== testbench/vdc_control_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vdc_control_port_checker (
  // Clocks and reset.
  input wire logic clk_sys_i,
  input wire logic pixel_clock_i,
  input wire logic reset_i,
  // Watched ports.
  input wire logic fast_float_n_i,
  input wire logic luma_bus_oe_o,
  input wire logic chroma_bus_oe_o,
  input wire logic sync_gate_oe_o,
  input wire logic [3:0] chroma_bus_o,
  input wire logic [8:0] increment_delay_o,
  input wire logic line_loop_open_o,
  input wire logic [7:0] standard_control_o
);
  // Eight pixels of request cover the input synchronizer with margin.
  sequence s_float_held;
    !fast_float_n_i [*8];
  endsequence
  sequence s_float_start;
    $fell(fast_float_n_i) && sync_gate_oe_o;
  endsequence
  chk_reset_float: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(reset_i) |-> !luma_bus_oe_o && !chroma_bus_oe_o && !sync_gate_oe_o && standard_control_o == 8'h00)
    else $error("outputs not floated after reset");
  chk_increment_delay_sign: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    increment_delay_o[8] == 1'b1) else $error("increment delay sign bit low");
  chk_increment_delay_range: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (increment_delay_o[7:0] < 8'h28) [*8] |-> line_loop_open_o) else $error("loop closed out of range");
  chk_loop_bit: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    standard_control_o[7] [*8] |-> line_loop_open_o) else $error("loop closed with open bit set");
  chk_float_luma: assert property (@(posedge pixel_clock_i) disable iff (reset_i)
    s_float_held |-> !luma_bus_oe_o) else $error("luma driven during float");
  chk_float_chroma: assert property (@(posedge pixel_clock_i) disable iff (reset_i)
    s_float_held |-> !chroma_bus_oe_o) else $error("chroma driven during float");
  chk_float_sync: assert property (@(posedge pixel_clock_i) disable iff (reset_i)
    s_float_start |=> sync_gate_oe_o [*4]) else $error("sync dropped by float");
  chk_colour_off: assert property (@(posedge pixel_clock_i) disable iff (reset_i)
    (!standard_control_o[4] && chroma_bus_oe_o) [*8] |-> chroma_bus_o == 4'h0) else $error("colour not off");
endmodule
bind vdc_control_port vdc_control_port_checker u_checker (
  .clk_sys_i, .pixel_clock_i, .reset_i, .fast_float_n_i, .luma_bus_oe_o, .chroma_bus_oe_o,
  .sync_gate_oe_o, .chroma_bus_o, .increment_delay_o, .line_loop_open_o, .standard_control_o
);
`default_nettype wire

// ===== testbench/vdc_control_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vdc_control_port_tb;
  logic clk_sys_i = 1'b0;
  logic pixel_clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic scl = 1'b1;
  logic sda_low = 1'b0;
  logic strap = 1'b0;
  logic float_req = 1'b0;
  logic killer_detect_i = 1'b0;
  logic [6:0] luma_in_i = 7'h11;
  logic [6:0] luma_limited_i = 7'h22;
  logic [3:0] chroma_in_i = 4'h9;
  logic sda_o, sda_oe_o, fast_float_n_i, luma_bus_oe_o, chroma_bus_oe_o, sync_gate_oe_o, line_loop_open_o;
  logic [3:0] chroma_bus_in_i, chroma_bus_o;
  logic [6:0] luma_bus_o, secam_chroma_delay_bits_o;
  logic [8:0] increment_delay_o;
  logic [7:0] line_sync_pulse_start_o, standard_control_o, input_delay_control_o, q;
  logic line_sync_out_o, field_sync_out_o, video_gate_out_o;
  logic [7:0] line_sync_pulse_stop_o, clamp_pulse_start_o, clamp_pulse_stop_o;
  logic [7:0] line_sync_out_start_o, luma_peaking_o, hue_phase_o;
  logic a;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  // The data line is open drain with a pull-up.
  wire sda = !(sda_low | sda_oe_o);
  // Two free-running clocks; every pixel clock edge lands on a system clock falling edge.
  always #5 clk_sys_i = !clk_sys_i;
  always #80 pixel_clock_i = !pixel_clock_i;
  vdc_control_port DUT (
    .clk_sys_i, .reset_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o, .addr_select_pin_i(strap),
    .pixel_clock_i, .fast_float_n_i, .killer_detect_i, .line_lock_flag_i(1'b1), .line_count_ident_i(1'b0),
    .chroma_bus_in_i, .luma_in_i, .luma_limited_i, .chroma_in_i, .sync_line_i(1'b1), .sync_field_i(1'b0),
    .video_gate_i(1'b1), .luma_bus_o, .luma_bus_oe_o, .chroma_bus_o, .chroma_bus_oe_o, .line_sync_out_o,
    .field_sync_out_o, .video_gate_out_o, .sync_gate_oe_o, .increment_delay_o, .line_loop_open_o,
    .line_sync_pulse_start_o, .line_sync_pulse_stop_o, .clamp_pulse_start_o, .clamp_pulse_stop_o,
    .line_sync_out_start_o, .luma_peaking_o, .hue_phase_o, .standard_control_o,
    .input_delay_control_o, .secam_chroma_delay_bits_o
  );
  vdc_pip_model PIP (
    .pixel_clock_i, .float_req_i(float_req), .fast_float_n_o(fast_float_n_i), .chroma_bus_in_o(chroma_bus_in_i)
  );
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus bit; the line is sampled in the middle of the high phase.
  task automatic bitx(input logic b, output logic r);
    sda_low = !b;
    w(10);
    scl = 1'b1;
    w(10);
    r = sda;
    w(10);
    scl = 1'b0;
    w(5);
  endtask
  // Eight bits MSB first, then the acknowledge bit; last high releases the line.
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] rq, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      rq[i] = r;
    end
    bitx(last, r);
    ack = !r;
  endtask
  task automatic sendb(input logic [7:0] d, input logic exp);
    xfer(d, 1'b1, q, a);
    chk(a, exp);
  endtask
  task automatic start;
    sda_low = 1'b0;
    w(5);
    scl = 1'b1;
    w(10);
    sda_low = 1'b1;
    w(10);
    scl = 1'b0;
    w(5);
  endtask
  task automatic stop;
    sda_low = 1'b1;
    w(5);
    scl = 1'b1;
    w(10);
    sda_low = 1'b0;
    w(20);
  endtask
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    start;
    sendb(addr, 1'b1);
    xfer(8'hFF, 1'b1, q, a);
    chk(q, exp);
    stop;
  endtask
  // Two-byte write; the settle time covers the pixel-side retiming.
  task automatic wr2(input logic [7:0] sub, input logic [7:0] d0, input logic [7:0] d1);
    start;
    sendb(8'h8A, 1'b1);
    sendb(sub, 1'b1);
    sendb(d0, 1'b1);
    sendb(d1, 1'b1);
    stop;
    w(200);
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // A hung handshake ends the run as a failure.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  // Main sequence; reset spans three pixel clocks so both domains see it.
  initial begin
    w(48);
    reset_i = 1'b0;
    w(10);
    chk({luma_bus_oe_o, chroma_bus_oe_o, sync_gate_oe_o}, 3'b000);
    chk(input_delay_control_o[7:3], 5'h00);
    killer_detect_i = 1'b1;
    w(14500);
    rd(8'h8B, 8'hE6);
    killer_detect_i = 1'b0;
    w(100);
    rd(8'h8B, 8'h62);
    start;
    sendb(8'h8E, 1'b0);
    stop;
    start;
    sendb(8'h8A, 1'b1);
    sendb(8'h08, 1'b1);
    sendb(8'h10, 1'b1);
    sendb(8'h60, 1'b1);
    sendb(8'hA5, 1'b1);
    sendb(8'hFF, 1'b1);
    sendb(8'h33, 1'b1);
    stop;
    w(200);
    chk(standard_control_o, 8'h10);
    chk(input_delay_control_o, 8'hA5);
    chk(secam_chroma_delay_bits_o, 7'h7F);
    chk({luma_bus_oe_o, chroma_bus_oe_o, sync_gate_oe_o}, 3'b111);
    start;
    sendb(8'h8A, 1'b1);
    sendb(8'h10, 1'b0);
    stop;
    for (int i = 0; i < 8; i++) begin
      killer_detect_i = i[0];
      wr2(8'h08, {3'b000, i[2], 4'h0}, {i[0], 2'b11, 1'b0, i[1], 3'b000});
      chk(chroma_bus_o, (i[2] && (i[1] || i[0])) ? 4'h9 : 4'h0);
      chk(luma_bus_o, i[0] ? 7'h22 : 7'h11);
    end
    for (int i = 0; i < 2; i++) begin
      wr2(8'h00, (i == 0) ? 8'h10 : 8'h80, 8'hC0);
      chk(increment_delay_o, (i == 0) ? 9'h110 : 9'h180);
      chk(line_loop_open_o, i == 0);
      chk(line_sync_pulse_start_o, 8'hC0);
    end
    // Timing registers in one burst, ending in 525-line mode with the line loop opened by its bit.
    start;
    sendb(8'h8A, 1'b1);
    sendb(8'h01, 1'b1);
    sendb(8'h5A, 1'b1);
    sendb(8'hA6, 1'b1);
    sendb(8'h7F, 1'b1);
    sendb(8'h80, 1'b1);
    sendb(8'h6A, 1'b1);
    sendb(8'hC3, 1'b1);
    sendb(8'h3C, 1'b1);
    sendb(8'hC0, 1'b1);
    stop;
    w(200);
    chk(line_sync_pulse_start_o, 8'h5A);
    chk(line_sync_pulse_stop_o, 8'hA6);
    chk(clamp_pulse_start_o, 8'h7F);
    chk(clamp_pulse_stop_o, 8'h80);
    chk(line_sync_out_start_o, 8'h6A);
    chk({luma_peaking_o, hue_phase_o}, 16'hC33C);
    chk(standard_control_o, 8'hC0);
    chk(line_loop_open_o, 1'b1);
    float_req = 1'b1;
    w(400);
    chk({luma_bus_oe_o, chroma_bus_oe_o, sync_gate_oe_o}, 3'b001);
    chk({line_sync_out_o, field_sync_out_o, video_gate_out_o, sda_o}, 4'b1010);
    float_req = 1'b0;
    w(400);
    chk({luma_bus_oe_o, chroma_bus_oe_o, sync_gate_oe_o}, 3'b111);
    strap = 1'b1;
    w(20);
    start;
    sendb(8'h8A, 1'b0);
    stop;
    rd(8'h8F, 8'h66);
    tally_and_finish;
  end
endmodule
`default_nettype wire
